/* capcfg_pkg.sv */
package capcfg_pkg;

  // Register selects within the configuration register group.
  localparam logic [2:0] SEL_CFG_THREE = 3'h3;
  localparam logic [2:0] SEL_CFG_FOUR  = 3'h4;
  localparam logic [2:0] SEL_CFG_FIVE  = 3'h5;

  // Field positions of the third configuration register.
  localparam int CFG3_M_BIT          = 31;
  localparam int CFG3_LVL_WIDTH_LO   = 21;
  localparam int CFG3_MCU_BIT        = 17;
  localparam int CFG3_EXC_ISA_BIT    = 16;
  localparam int CFG3_ISA_LO         = 14;
  localparam int CFG3_USER_LOCAL_BIT = 13;
  localparam int CFG3_DSP2_BIT       = 11;
  localparam int CFG3_DSP_BIT        = 10;
  localparam int CFG3_WIDE_PA_BIT    = 7;
  localparam int CFG3_EIC_BIT        = 6;
  localparam int CFG3_VEC_IRQ_BIT    = 5;
  localparam int CFG3_TINY_PAGE_BIT  = 4;
  localparam int CFG3_DEV_MAP_BIT    = 3;
  localparam int CFG3_SECURE_BIT     = 1;
  localparam int CFG3_TRACE_BIT      = 0;

  // Field positions of the fourth and fifth configuration registers.
  localparam int CFG4_M_BIT          = 31;
  localparam int CFG4_IE_LO          = 29;
  localparam int CFG4_SCRATCH_LO     = 16;
  localparam int CFG5_M_BIT          = 31;
  localparam int CFG5_FPR_ACCESS_BIT = 2;

  // Constant and reset values.
  localparam logic [1:0] LVL_WIDTH_VALUE    = 2'h1;
  localparam logic       MCU_VALUE          = 1'h1;
  localparam logic       USER_LOCAL_VALUE   = 1'h1;
  localparam logic       WIDE_PA_VALUE      = 1'h0;
  localparam logic       VEC_IRQ_VALUE      = 1'h1;
  localparam logic       TINY_PAGE_VALUE    = 1'h0;
  localparam logic       SECURE_VALUE       = 1'h0;
  localparam logic       CFG4_M_VALUE       = 1'h1;
  localparam logic [1:0] TLB_INV_VALUE      = 2'h1;
  localparam logic [7:0] SCRATCH_MASK_VALUE = 8'h0C;
  localparam logic       CFG5_M_VALUE       = 1'h0;
  localparam logic       FPR_ACCESS_RESET   = 1'h0;
  localparam logic       LVL_TOP_FROM_CAUSE = 1'h1;

  // Cause register positions that carry the two top requested-level bits.
  localparam int CAUSE_LVL_HI_BIT  = 17;
  localparam int CAUSE_LVL_MID_BIT = 16;

  // Write sequencing state.
  typedef enum logic [0:0] {
    CAP_LOAD,
    CAP_RUN
  } cap_state_type;

endpackage : capcfg_pkg

/* reset_sync.sv */
module reset_sync (
  // Clock and raw reset
  input  wire logic clk_i,
  input  wire logic resetn_i,
  // Released reset
  output logic      rst_n_o
);

  logic meta_ff;
  logic hold_ff;

  // The first stage feeds only the second, so release never races into the block.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_ff <= 1'b0;
      hold_ff <= 1'b0;
    end else begin
      meta_ff <= 1'b1;
      hold_ff <= meta_ff;
    end
  end

  assign rst_n_o = hold_ff;

endmodule : reset_sync

/* rw_bit.sv */
module rw_bit (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Load and write controls
  input  wire logic load_i,
  input  wire logic load_val_i,
  input  wire logic wr_i,
  input  wire logic wr_val_i,
  // Stored value
  output logic      q_o
);

  logic bit_ff;
  logic nxt_bit;

  always_comb begin
    nxt_bit = bit_ff;
    if (load_i) begin
      nxt_bit = load_val_i;
    end else if (wr_i) begin
      nxt_bit = wr_val_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_ff <= 1'b0;
    end else begin
      bit_ff <= nxt_bit;
    end
  end

  assign q_o = bit_ff;

endmodule : rw_bit

/* capability_config_regs.sv */
// Functional notes
// R1: Interrupt level width code reads 1: eight-bit level fields.
// R2: Eight-bit requested level takes cause bits 17 and 16 as top bits.
// R3: Microcontroller extension bit 17 is read-only one.
// R4: Exception-entry set bit 16 is writable; reset value from external signal.
// R5: Instruction set availability field preset from external signal.
// R6: User-local present bit 13 reads one.
// R7: Bits 11 and 10 report signal-processing revision 2 and presence presets.
// R8: Wide physical address bit 7 reads zero.
// R9: Bit 6 follows the external interrupt controller strap.
// R10: Vectored interrupt bit 5 always reads one.
// R11: Tiny page bit 4 reads zero.
// R12: Bit 3 reports the common device memory map preset.
// R13: Security extension bit 1 always reads zero.
// R14: Bit 0 reports the trace logic preset.
// R15: Fourth register bit 31 reads one: a fifth register exists.
// R16: TLB invalidate field reads code 01, entry-invalidate bit only.
// R17: Kernel scratch mask bits 23:16 read 0x0C.
// R18: Reserved bits of fourth and fifth registers read zero; software writes zero.
// R19: Fifth register bit 31 reads zero: no further register.
// R20: Fifth register bit 2 resets to zero and gates user floating mode access.
// R21: User-mode floating register-mode instructions allowed only when that bit is one.
// R22: Writes to read-only capability fields have no effect.
module capability_config_regs
  import capcfg_pkg::*;
#(
  parameter logic DSP2_PRESENT  = 1'b1,
  parameter logic DSP_PRESENT   = 1'b1,
  parameter logic DEV_MAP_PRESENT = 1'b1,
  parameter logic TRACE_PRESENT = 1'b1
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // Static straps
  input  wire logic        exc_iset_strap_i,
  input  wire logic [1:0]  iset_avail_strap_i,
  input  wire logic        ext_intc_strap_input_i,
  // Coprocessor register access
  input  wire logic [2:0]  sel_i,
  input  wire logic        rd_en_i,
  input  wire logic        wr_en_i,
  input  wire logic [31:0] wr_data_i,
  output logic [31:0]      rd_data_o,
  // Requested interrupt level assembly
  input  wire logic [31:0] cause_i,
  input  wire logic [5:0]  requested_interrupt_level_low_i,
  output logic [7:0]       requested_interrupt_level_o,
  // Feature controls
  input  wire logic        user_mode_i,
  input  wire logic        fpr_mode_access_req_i,
  output logic             fpr_mode_access_ok_o,
  output logic             exception_entry_iset_o,
  output logic             user_fpr_mode_access_o
);

  logic          rst_n;
  cap_state_type state_ff;
  cap_state_type nxt_state;
  logic [1:0]    iset_avail_ff;
  logic [1:0]    nxt_iset_avail;
  logic          exception_entry_iset;
  logic          user_fpr_mode_access;
  logic          load;
  logic          wr_three;
  logic          wr_five;
  logic [31:0]   cfg_three;
  logic [31:0]   cfg_four;
  logic [31:0]   cfg_five;
  logic [31:0]   nxt_rd_data;
  logic [31:0]   rd_data_ff;

  reset_sync u_reset_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .rst_n_o  (rst_n)
  );

  // The exception-set and instruction-set straps are caught one clock after reset release, never inside the async reset.
  always_comb begin
    nxt_state      = state_ff;
    nxt_iset_avail = iset_avail_ff;
    case (state_ff)
      CAP_LOAD: begin
        nxt_iset_avail = iset_avail_strap_i; // R5
        nxt_state      = CAP_RUN;
      end
      CAP_RUN: begin
        nxt_state = CAP_RUN;
      end
      default: begin
        nxt_state = CAP_LOAD;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_ff      <= CAP_LOAD;
      iset_avail_ff <= 2'h0;
    end else begin
      state_ff      <= nxt_state;
      iset_avail_ff <= nxt_iset_avail;
    end
  end

  assign load     = (state_ff == CAP_LOAD);
  assign wr_three = wr_en_i && (sel_i == SEL_CFG_THREE) && !load;
  assign wr_five  = wr_en_i && (sel_i == SEL_CFG_FIVE) && !load;

  rw_bit u_exc_iset (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n),
    .load_i     (load),
    .load_val_i (exc_iset_strap_i),
    .wr_i       (wr_three),
    .wr_val_i   (wr_data_i[CFG3_EXC_ISA_BIT]), // R4
    .q_o        (exception_entry_iset)
  );

  rw_bit u_fpr_access (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n),
    .load_i     (load),
    .load_val_i (FPR_ACCESS_RESET), // R20
    .wr_i       (wr_five),
    .wr_val_i   (wr_data_i[CFG5_FPR_ACCESS_BIT]), // R20
    .q_o        (user_fpr_mode_access)
  );

  // Only the two writable bits take write data; all else is rebuilt from constants and straps.
  always_comb begin
    cfg_three = 32'h0000_0000;
    cfg_three[CFG3_M_BIT]                   = 1'b1;
    cfg_three[CFG3_LVL_WIDTH_LO +: 2]       = LVL_WIDTH_VALUE; // R1
    cfg_three[CFG3_MCU_BIT]                 = MCU_VALUE; // R3
    cfg_three[CFG3_EXC_ISA_BIT]             = exception_entry_iset; // R4
    cfg_three[CFG3_ISA_LO +: 2]             = iset_avail_ff; // R5
    cfg_three[CFG3_USER_LOCAL_BIT]          = USER_LOCAL_VALUE; // R6
    cfg_three[CFG3_DSP2_BIT]                = DSP2_PRESENT; // R7
    cfg_three[CFG3_DSP_BIT]                 = DSP_PRESENT; // R7
    cfg_three[CFG3_WIDE_PA_BIT]             = WIDE_PA_VALUE; // R8
    cfg_three[CFG3_EIC_BIT]                 = ext_intc_strap_input_i; // R9
    cfg_three[CFG3_VEC_IRQ_BIT]             = VEC_IRQ_VALUE; // R10
    cfg_three[CFG3_TINY_PAGE_BIT]           = TINY_PAGE_VALUE; // R11
    cfg_three[CFG3_DEV_MAP_BIT]             = DEV_MAP_PRESENT; // R12
    cfg_three[CFG3_SECURE_BIT]              = SECURE_VALUE; // R13
    cfg_three[CFG3_TRACE_BIT]               = TRACE_PRESENT; // R14
  end

  always_comb begin
    cfg_four = 32'h0000_0000; // R18
    cfg_four[CFG4_M_BIT]         = CFG4_M_VALUE; // R15
    cfg_four[CFG4_IE_LO +: 2]    = TLB_INV_VALUE; // R16
    cfg_four[CFG4_SCRATCH_LO +: 8] = SCRATCH_MASK_VALUE; // R17
  end

  always_comb begin
    cfg_five = 32'h0000_0000; // R18
    cfg_five[CFG5_M_BIT]   = CFG5_M_VALUE; // R19
    cfg_five[CFG5_FPR_ACCESS_BIT] = user_fpr_mode_access; // R20
  end

  // Read data is registered; unknown selects read zero, and writes to them are dropped.
  always_comb begin
    nxt_rd_data = rd_data_ff;
    if (rd_en_i) begin
      case (sel_i)
        SEL_CFG_THREE: nxt_rd_data = cfg_three;
        SEL_CFG_FOUR:  nxt_rd_data = cfg_four; // R22
        SEL_CFG_FIVE:  nxt_rd_data = cfg_five;
        default:       nxt_rd_data = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= 32'h0000_0000;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data_o = rd_data_ff;

  // With the width code fixed at eight bits, the top level bits come from the cause word.
  assign requested_interrupt_level_o = {cause_i[CAUSE_LVL_HI_BIT],
                                        cause_i[CAUSE_LVL_MID_BIT],
                                        requested_interrupt_level_low_i}; // R2

  // Kernel mode is never gated; user mode needs the access bit set.
  assign fpr_mode_access_ok_o = fpr_mode_access_req_i &&
                                (!user_mode_i || user_fpr_mode_access); // R21

  assign exception_entry_iset_o = exception_entry_iset;
  assign user_fpr_mode_access_o = user_fpr_mode_access;

endmodule : capability_config_regs

/* capability_config_regs_properties.sv */
module capcfg_checker
  import capcfg_pkg::*;
#(
  parameter logic DSP2_PRESENT  = 1'b1,
  parameter logic DSP_PRESENT   = 1'b1,
  parameter logic DEV_MAP_PRESENT = 1'b1,
  parameter logic TRACE_PRESENT = 1'b1
) (
  // Clock, reset and straps
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        exc_iset_strap_i,
  input wire logic [1:0]  iset_avail_strap_i,
  input wire logic        ext_intc_strap_input_i,
  // Register access
  input wire logic [2:0]  sel_i,
  input wire logic        rd_en_i,
  input wire logic        wr_en_i,
  input wire logic [31:0] wr_data_i,
  input wire logic [31:0] rd_data_o,
  // Level and feature controls
  input wire logic [31:0] cause_i,
  input wire logic [5:0]  requested_interrupt_level_low_i,
  input wire logic [7:0]  requested_interrupt_level_o,
  input wire logic        user_mode_i,
  input wire logic        fpr_mode_access_req_i,
  input wire logic        fpr_mode_access_ok_o,
  input wire logic        exception_entry_iset_o,
  input wire logic        user_fpr_mode_access_o
);
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [31:0] CFG3_FIXED = 32'h80222020 | {20'h0, DSP2_PRESENT, DSP_PRESENT, 6'h0,
                                                       DEV_MAP_PRESENT, 2'h0, TRACE_PRESENT};
  localparam logic [31:0] CFG3_MASK  = 32'hFFFE3FBF;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  chk_cfg3_fixed: assert property (rd_en_i && sel_i == SEL_CFG_THREE
    |=> (rd_data_o & CFG3_MASK) == CFG3_FIXED) else $error("third register fixed bits wrong");
  chk_cfg3_live: assert property (rd_en_i && sel_i == SEL_CFG_THREE
    |=> rd_data_o[6] == $past(ext_intc_strap_input_i) && rd_data_o[16] == $past(exception_entry_iset_o))
    else $error("third register strap or exception set bit wrong");
  chk_cfg4_value: assert property (rd_en_i && sel_i == SEL_CFG_FOUR
    |=> rd_data_o == 32'hA00C0000) else $error("fourth register value wrong");
  chk_cfg5_value: assert property (rd_en_i && sel_i == SEL_CFG_FIVE
    |=> rd_data_o == {29'h0, $past(user_fpr_mode_access_o), 2'h0}) else $error("fifth register wrong");
  chk_access_write: assert property (wr_en_i && sel_i == SEL_CFG_FIVE
    |=> user_fpr_mode_access_o == $past(wr_data_i[2])) else $error("access bit write lost");
  chk_access_hold: assert property (!(wr_en_i && sel_i == SEL_CFG_FIVE)
    |=> $stable(user_fpr_mode_access_o)) else $error("access bit changed without write");
  chk_exc_write: assert property (wr_en_i && sel_i == SEL_CFG_THREE
    |=> exception_entry_iset_o == $past(wr_data_i[16])) else $error("exception set bit write lost");
  chk_level_bits: assert property (
    requested_interrupt_level_o == {cause_i[17:16], requested_interrupt_level_low_i}) else $error("level assembly wrong");
  chk_mode_gate: assert property (
    fpr_mode_access_ok_o == (fpr_mode_access_req_i && (!user_mode_i || user_fpr_mode_access_o)))
    else $error("mode access gate wrong");

  cov_cfg3_read: cover property (rd_en_i && sel_i == SEL_CFG_THREE);
  cov_access_write: cover property (wr_en_i && sel_i == SEL_CFG_FIVE && wr_data_i[2]);
  cov_gate_denied: cover property (fpr_mode_access_req_i && user_mode_i && !fpr_mode_access_ok_o);
endmodule : capcfg_checker

/* capability_config_regs_bench.sv */
module capability_config_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import capcfg_pkg::*;
  logic        clk_i, resetn_i, exc_iset_strap_i, ext_intc_strap_input_i;
  logic        rd_en_i, wr_en_i, user_mode_i, fpr_mode_access_req_i;
  logic        fpr_mode_access_ok_o, exception_entry_iset_o, user_fpr_mode_access_o;
  logic [1:0]  iset_avail_strap_i;
  logic [2:0]  sel_i;
  logic [5:0]  requested_interrupt_level_low_i;
  logic [7:0]  requested_interrupt_level_o;
  logic [31:0] wr_data_i, cause_i, rd_data_o;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          cycles = 0;

  capability_config_regs dut (.clk_i, .resetn_i, .exc_iset_strap_i, .iset_avail_strap_i,
    .ext_intc_strap_input_i, .sel_i, .rd_en_i, .wr_en_i, .wr_data_i, .rd_data_o, .cause_i,
    .requested_interrupt_level_low_i, .requested_interrupt_level_o, .user_mode_i, .fpr_mode_access_req_i,
    .fpr_mode_access_ok_o, .exception_entry_iset_o, .user_fpr_mode_access_o);

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic report_and_stop();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  // Six idle edges let the internal reset release and the strap load edge pass.
  task automatic do_reset(logic e, logic [1:0] i, logic s);
    @(posedge clk_i);
    resetn_i <= 1'b0;
    exc_iset_strap_i <= e;
    iset_avail_strap_i <= i;
    ext_intc_strap_input_i <= s;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask : do_reset

  task automatic rd(logic [2:0] s, logic [31:0] exp, string what);
    @(posedge clk_i);
    sel_i <= s;
    rd_en_i <= 1'b1;
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    @(negedge clk_i);
    check(what, exp, rd_data_o);
  endtask : rd

  task automatic wr(logic [2:0] s, logic [31:0] d);
    @(posedge clk_i);
    sel_i <= s;
    wr_data_i <= d;
    wr_en_i <= 1'b1;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
  endtask : wr

  task automatic t_presets();
    logic [1:0] k;
    for (int n = 0; n < 4; n++) begin
      k = 2'(n);
      do_reset(k[0], k, k[1]);
      rd(3'h3, 32'h80222C29 | {15'h0, k[0], k, 7'h0, k[1], 6'h0}, "cfg3");
      check("exc_iset", {31'h0, k[0]}, {31'h0, exception_entry_iset_o});
    end
  endtask : t_presets

  task automatic t_read_only();
    wr(3'h3, 32'h00000000);
    rd(3'h3, 32'h8022EC69, "cfg3 after write");
    wr(3'h3, 32'hFFFFFFFF);
    rd(3'h3, 32'h8023EC69, "cfg3 after ones");
    wr(3'h4, 32'hFFFFFFFF);
    rd(3'h4, 32'hA00C0000, "cfg4");
    rd(3'h0, 32'h00000000, "unmapped 0");
    rd(3'h7, 32'h00000000, "unmapped 7");
  endtask : t_read_only

  task automatic t_fpr_access();
    check("access reset", 32'h0, {31'h0, user_fpr_mode_access_o});
    for (int u = 1; u >= 0; u--) begin
      wr(3'h5, u[0] ? 32'hFFFFFFFF : 32'h0);
      rd(3'h5, {29'h0, u[0], 2'h0}, "cfg5");
      for (int m = 0; m < 4; m++) begin
        @(posedge clk_i);
        user_mode_i <= m[0];
        fpr_mode_access_req_i <= m[1];
        @(negedge clk_i);
        check("gate", {31'h0, m[1] && (!m[0] || u[0])}, {31'h0, fpr_mode_access_ok_o});
      end
    end
    // A set access bit must fall back to zero on a mid-run reset.
    wr(3'h5, 32'h00000004);
    do_reset(1'b0, 2'h2, 1'b0);
    check("access after reset", 32'h0, {31'h0, user_fpr_mode_access_o});
  endtask : t_fpr_access

  task automatic t_level();
    @(posedge clk_i);
    cause_i <= 32'hFFFEFFFF;
    requested_interrupt_level_low_i <= 6'h15;
    @(negedge clk_i);
    check("level", 32'h95, {24'h0, requested_interrupt_level_o});
    @(posedge clk_i);
    cause_i <= 32'h00010000;
    requested_interrupt_level_low_i <= 6'h2A;
    @(negedge clk_i);
    check("level", 32'h6A, {24'h0, requested_interrupt_level_o});
  endtask : t_level

  initial begin
    {resetn_i, exc_iset_strap_i, ext_intc_strap_input_i, rd_en_i, wr_en_i} = 5'h0;
    {user_mode_i, fpr_mode_access_req_i, iset_avail_strap_i, sel_i} = 7'h0;
    {wr_data_i, cause_i, requested_interrupt_level_low_i} = 70'h0;
    t_presets();
    t_read_only();
    t_fpr_access();
    t_level();
    report_and_stop();
  end
endmodule : capability_config_regs_bench

bind capability_config_regs capcfg_checker #(.DSP2_PRESENT(DSP2_PRESENT),
  .DSP_PRESENT(DSP_PRESENT), .DEV_MAP_PRESENT(DEV_MAP_PRESENT), .TRACE_PRESENT(TRACE_PRESENT))
  chk (.clk_i, .resetn_i, .exc_iset_strap_i, .iset_avail_strap_i, .ext_intc_strap_input_i,
  .sel_i, .rd_en_i, .wr_en_i, .wr_data_i, .rd_data_o, .cause_i, .requested_interrupt_level_low_i,
  .requested_interrupt_level_o, .user_mode_i, .fpr_mode_access_req_i, .fpr_mode_access_ok_o,
  .exception_entry_iset_o, .user_fpr_mode_access_o);
